// File: rtl/lkpm_pin_mux.sv
// Purpose: Phase-driven function mux for cathode and segment lines of an LED matrix with keyscan.
// Assumes: Phase, display data and scan strobes come from the sequencer, synchronous to clock.
// Notes:   All pin controls are registered; pins change one cycle after phase and data, two after alertSelWrite; the alert level two after alertReq.
//
// Functional notes
// RL1: Cathodes drive low to select in display.
// RL2: First cathode drives high in reset, scan.
// RL3: Cathodes two to four drive high when active in scan.
// RL4: Segments drive high when active in display.
// RL5: Strap segments read with pull-down in reset/scan.
// RL6: Key returns become pulled-down inputs, sampled.
// RL7: Select zero: shared line is segment/key.
// RL8: Select one: shared line only alert output.
// RL9: Polarity zero: alert drives low when asserted.
// RL10: Polarity one: alert drives high when asserted.
// RL11: Reset leaves shared line as segment.
// RL12: Strap, return counts and alert position parameterised.
`timescale 1ns/100ps
`default_nettype none
module lkpm_pin_mux
	import lkpm_pkg::*;
#(
	// RL12: variant parameters
	parameter int NUM_STRAPS  = DEF_NUM_STRAPS,
	parameter int NUM_RETURNS = DEF_NUM_RETURNS,
	parameter int ALERT_INDEX = DEF_ALERT_INDEX
)(
	input  wire logic                    clock,
	input  wire logic                    resetn,
	input  wire lkpm_phase_t             phase,
	input  wire logic [NUM_CATHODES-1:0] cathodeSelect,
	input  wire logic [NUM_SEGMENTS-1:0] segmentData,
	input  wire logic [NUM_SCAN_SOURCES-1:0] scanSourceActive,
	input  wire logic                    alertSelWrite,
	input  wire logic                    alertSelValue,
	input  wire logic                    alertPolValue,
	input  wire logic                    alertReq,
	input  wire logic [NUM_SEGMENTS-1:0] segmentIn,
	output lkpm_cath_pins_t              cathodePins,
	output lkpm_seg_pins_t               segmentPins,
	output logic [NUM_SEGMENTS-1:0]      keyData,
	output logic [NUM_SEGMENTS-1:0]      strapData,
	output logic                         alertSelected
);

	// Masks of segment roles, built once from the variant parameters.
	function automatic logic [NUM_SEGMENTS-1:0] roleMask(input int lo, input int cnt);
		logic [NUM_SEGMENTS-1:0] m;
		m = '0;
		for (int i = 0; i < NUM_SEGMENTS; i++) begin
			if (i >= lo && i < lo + cnt) begin
				m[i] = 1'b1;
			end
		end
		return m;
	endfunction

	localparam logic [NUM_SEGMENTS-1:0] STRAP_MASK  = roleMask(0, NUM_STRAPS);
	localparam logic [NUM_SEGMENTS-1:0] RETURN_MASK = roleMask(NUM_STRAPS, NUM_RETURNS + 1);
	localparam logic [NUM_SEGMENTS-1:0] SHARED_MASK = roleMask(ALERT_INDEX, 1);

	typedef struct packed {
		lkpm_cath_pins_t         cath;
		lkpm_seg_pins_t          seg;
		logic [NUM_SEGMENTS-1:0] keys;
		logic [NUM_SEGMENTS-1:0] straps;
		logic                    alertSel;
		logic                    alertPol;
	} lkpm_mux_st_t;

	lkpm_mux_st_t state_reg;
	lkpm_mux_st_t state_next;
	logic         alertLevel;

	// ==========================================================
	// Alert level generation lives in its own small module.
	lkpm_alert_drive u_alert (
		.clock      (clock),
		.resetn     (resetn),
		.alertSel   (state_reg.alertSel),
		.alertPol   (state_reg.alertPol),
		.alertReq   (alertReq),
		.alertLevel (alertLevel)
	);

	// ==========================================================
	// Next-state: pin functions per phase.
	always_comb begin
		state_next = state_reg;
		if (alertSelWrite) begin
			state_next.alertSel = alertSelValue;
			state_next.alertPol = alertPolValue;
		end
		state_next.cath.out = '1;
		state_next.cath.oe  = '0;
		state_next.seg.out  = '0;
		state_next.seg.oe   = '0;
		state_next.seg.pd   = '0;
		unique case (phase)
			LKPM_PH_DISPLAY: begin
				// RL1: active-low cathodes
				state_next.cath.out = ~cathodeSelect;
				state_next.cath.oe  = '1;
				// RL4: active-high segments
				// RL5: straps drive as segments otherwise
				state_next.seg.out = segmentData;
				state_next.seg.oe  = '1;
			end
			LKPM_PH_SCAN: begin
				// RL2: strap source high
				state_next.cath.out[STRAP_SOURCE_IDX] = 1'b1;
				state_next.cath.oe[STRAP_SOURCE_IDX]  = 1'b1;
				// RL3: scan sources high when active
				for (int k = 0; k < NUM_SCAN_SOURCES; k++) begin
					state_next.cath.out[SCAN_SOURCE_BASE+k] = scanSourceActive[k];
					state_next.cath.oe[SCAN_SOURCE_BASE+k]  = 1'b1;
				end
				// RL5: strap inputs pulled down
				// RL6: key returns pulled down
				state_next.seg.pd = STRAP_MASK | RETURN_MASK;
				state_next.straps = segmentIn & STRAP_MASK;
				state_next.keys   = segmentIn & RETURN_MASK;
			end
			LKPM_PH_POR: begin
				// RL2: strap source high at reset
				state_next.cath.out[STRAP_SOURCE_IDX] = 1'b1;
				state_next.cath.oe[STRAP_SOURCE_IDX]  = 1'b1;
				// RL5: straps read at reset
				state_next.seg.pd = STRAP_MASK;
				state_next.straps = segmentIn & STRAP_MASK;
			end
			LKPM_PH_IDLE: begin
				// RL5: straps driven as unlit segments
				// Cathodes and other segments float, bar an alert-selected shared line; straps stay outputs but drive low, so nothing lights.
				state_next.cath.oe = '0;
				state_next.seg.oe  = STRAP_MASK;
			end
		endcase
		// RL8: shared line becomes alert only
		if (state_reg.alertSel) begin
			state_next.seg.out[ALERT_INDEX] = alertLevel;
			state_next.seg.oe[ALERT_INDEX]  = 1'b1;
			state_next.seg.pd[ALERT_INDEX]  = 1'b0;
			state_next.keys[ALERT_INDEX]    = 1'b0;
		end
		// RL7: select zero keeps segment/key role through the phase logic above.
	end

	// ==========================================================
	// State register; reset leaves the shared line as a segment line.
	always_ff @(posedge clock) begin
		if (!resetn) begin
			state_reg.cath.out <= '1;
			state_reg.cath.oe  <= '0;
			state_reg.seg      <= '0;
			state_reg.keys     <= '0;
			state_reg.straps   <= '0;
			// RL11: alert off after reset
			state_reg.alertSel <= RST_ALERT_SEL;
			state_reg.alertPol <= RST_ALERT_POL;
		end else begin
			state_reg <= state_next;
		end
	end

	assign cathodePins   = state_reg.cath;
	assign segmentPins   = state_reg.seg;
	assign keyData       = state_reg.keys;
	assign strapData     = state_reg.straps;
	assign alertSelected = state_reg.alertSel;

	// ==========================================================
	// Checks.
	disp_cath_a: assert property (@(posedge clock) disable iff (!resetn)
		(phase == LKPM_PH_DISPLAY) |=> (cathodePins.out == ~$past(cathodeSelect)))   // RL1
		else $error("display cathode level wrong");
	src_high_a: assert property (@(posedge clock) disable iff (!resetn)
		(phase == LKPM_PH_SCAN || phase == LKPM_PH_POR)
		|=> (cathodePins.out[0] && cathodePins.oe[0]))   // RL2
		else $error("strap source not high");
	scan_src_a: assert property (@(posedge clock) disable iff (!resetn)
		(phase == LKPM_PH_SCAN) |=> (cathodePins.out[3:1] == $past(scanSourceActive)))   // RL3
		else $error("scan source level wrong");
	disp_seg_a: assert property (@(posedge clock) disable iff (!resetn)
		(phase == LKPM_PH_DISPLAY && !alertSelected)
		|=> (segmentPins.out == $past(segmentData) && segmentPins.oe == '1))   // RL4
		else $error("display segment level wrong");
	strap_in_a: assert property (@(posedge clock) disable iff (!resetn)
		(phase == LKPM_PH_POR) |=> ((segmentPins.oe & STRAP_MASK) == '0 && (segmentPins.pd & STRAP_MASK) == STRAP_MASK))   // RL5
		else $error("strap lines not inputs");
	strap_drive_a: assert property (@(posedge clock) disable iff (!resetn)   // RL5
		(phase == LKPM_PH_IDLE)
		|=> ((segmentPins.oe & STRAP_MASK) == STRAP_MASK && (segmentPins.out & STRAP_MASK) == '0))
		else $error("strap lines not driven");
	key_sample_a: assert property (@(posedge clock) disable iff (!resetn)
		(phase == LKPM_PH_SCAN && !alertSelected)
		|=> (keyData == ($past(segmentIn) & RETURN_MASK)))   // RL6
		else $error("key data not sampled");
	shared_key_a: assert property (@(posedge clock) disable iff (!resetn)
		(phase == LKPM_PH_SCAN && !alertSelected) |=> segmentPins.pd[ALERT_INDEX])   // RL7
		else $error("shared line not key return");
	alert_only_a: assert property (@(posedge clock) disable iff (!resetn)
		alertSelected |=> (segmentPins.oe[ALERT_INDEX] && !keyData[ALERT_INDEX]))   // RL8
		else $error("shared line not alert");
	reset_seg_a: assert property (@(posedge clock)
		!resetn |=> !alertSelected)   // RL11
		else $error("alert on after reset");

endmodule
`default_nettype wire

// File: rtl/lkpm_pkg.sv
// Purpose: Shared constants and carrier types for the LED/key pin function mux.
// Assumes: Default variant is the largest package (3 straps, 12 key returns, shared line 15).
// Notes:   Phase codes drive the pin mux; all widths fixed.
package lkpm_pkg;

	// ==========================================================
	// Geometry
	localparam int NUM_CATHODES     = 8;
	localparam int NUM_SEGMENTS     = 16;
	localparam int NUM_SCAN_SOURCES = 3;
	localparam int SCAN_SOURCE_BASE = 1;
	localparam int STRAP_SOURCE_IDX = 0;
	localparam int DEF_NUM_STRAPS   = 3;
	localparam int DEF_NUM_RETURNS  = 12;
	localparam int DEF_ALERT_INDEX  = 15;

	// ==========================================================
	// Reset values
	localparam logic RST_ALERT_SEL = 1'h0;
	localparam logic RST_ALERT_POL = 1'h0;

	// ==========================================================
	// Phases
	typedef enum logic [1:0] {
		LKPM_PH_POR     = 2'h0,
		LKPM_PH_DISPLAY = 2'h1,
		LKPM_PH_SCAN    = 2'h2,
		LKPM_PH_IDLE    = 2'h3
	} lkpm_phase_t;

	// One pin group: output level, output enable and pull-down enable.
	typedef struct packed {
		logic [NUM_SEGMENTS-1:0] out;
		logic [NUM_SEGMENTS-1:0] oe;
		logic [NUM_SEGMENTS-1:0] pd;
	} lkpm_seg_pins_t;

	typedef struct packed {
		logic [NUM_CATHODES-1:0] out;
		logic [NUM_CATHODES-1:0] oe;
	} lkpm_cath_pins_t;

endpackage

// File: rtl/lkpm_alert_drive.sv
// Purpose: Registered alert output level with selectable polarity.
// Assumes: Alert request is synchronous to clock.
// Notes:   Output forced inactive while the alert function is off.
`timescale 1ns/100ps
`default_nettype none
module lkpm_alert_drive
	import lkpm_pkg::*;
(
	input  wire logic clock,
	input  wire logic resetn,
	input  wire logic alertSel,
	input  wire logic alertPol,
	input  wire logic alertReq,
	output var  logic alertLevel
);

	typedef struct packed {
		logic level;
	} lkpm_alert_st_t;

	lkpm_alert_st_t state_reg;
	lkpm_alert_st_t state_next;

	// ==========================================================
	// Level: asserted means low when polarity is 0, high when 1.
	always_comb begin
		state_next = state_reg;
		// RL9: low-active polarity
		// RL10: high-active polarity
		state_next.level = (alertSel & alertReq) ? alertPol : ~alertPol;
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			state_reg.level <= ~RST_ALERT_POL;
		end else begin
			state_reg <= state_next;
		end
	end

	assign alertLevel = state_reg.level;

	// RL9: polarity zero check
	alert_low_a: assert property (@(posedge clock) disable iff (!resetn)
		(alertSel && !alertPol) |=> (alertLevel == !$past(alertReq)))   // RL9
		else $error("alert level wrong for low polarity");
	// RL10: polarity one check
	alert_high_a: assert property (@(posedge clock) disable iff (!resetn)
		(alertSel && alertPol) |=> (alertLevel == $past(alertReq)))   // RL10
		else $error("alert level wrong for high polarity");

endmodule
`default_nettype wire

// File: tb/lkpm_matrix_model.sv
// Purpose: Behavioural LED matrix and key switch matrix seen from the segment lines.
// Assumes: Strap levels and pressed keys are set by the bench.
// Notes:   A floating line toggles each cycle so a stale level never passes.
`timescale 1ns/100ps
`default_nettype none
module lkpm_matrix_model
	import lkpm_pkg::*;
(
	input  wire logic            clock,
	input  wire lkpm_cath_pins_t cathodePins,
	input  wire lkpm_seg_pins_t  segmentPins,
	input  wire logic [2:0]      strapLevel,
	input  wire logic [15:0]     keyPressed,
	output logic [15:0]          segmentIn
);
	logic [15:0] flipReg = 16'hA5A5;
	logic        srcHigh;
	// ==========================================================
	// A pressed key only lifts its return while a scan source drives high.
	assign srcHigh = |(cathodePins.out[3:1] & cathodePins.oe[3:1]);
	// The toggle stands in for an undriven line with no pull-down.
	always_ff @(posedge clock) begin
		flipReg <= ~flipReg;
	end
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			if (segmentPins.oe[i])
				segmentIn[i] = segmentPins.out[i];
			else if (segmentPins.pd[i])
				segmentIn[i] = (i < 3) ? strapLevel[i] : keyPressed[i] & srcHigh;
			else
				segmentIn[i] = flipReg[i];
		end
	end
endmodule
`default_nettype wire

// File: tb/led_key_pin_function_mux_tb.sv
// Purpose: Self-checking bench for the LED/key pin function mux.
// Assumes: Pins answer one cycle after phase and data, the alert level two.
// Notes:   Key data is judged on a second scan cycle, once the sources drive.
`timescale 1ns/100ps
`default_nettype none
module led_key_pin_function_mux_tb;
	import lkpm_pkg::*;
	typedef struct {
		int          due;
		logic [7:0]  cOutE, cMask;
		logic [15:0] sOutE, sOutM, sOeE, sPdE, sMask, kExp;
		bit          kChk, stChk;
	} lkpm_note_t;
	logic clock, resetn, selWr, sel, pol, req;
	lkpm_phase_t phase;
	logic [7:0] cs;
	logic [15:0] sd, keys, segIn, keyData, strapData;
	logic [2:0] ss, strap;
	logic alertSelected;
	lkpm_cath_pins_t cathodePins;
	lkpm_seg_pins_t segmentPins;
	lkpm_note_t notes[$];
	lkpm_note_t m;
	int cyc = 0, err_count = 0, compares = 0;
	integer seed = 32'h1d256612;
	// ==========================================================
	// Clock, cycle count and hang guard.
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	lkpm_pin_mux dut (.clock(clock), .resetn(resetn), .phase(phase), .cathodeSelect(cs), .segmentData(sd),
		.scanSourceActive(ss), .alertSelWrite(selWr), .alertSelValue(sel), .alertPolValue(pol),
		.alertReq(req), .segmentIn(segIn), .cathodePins(cathodePins), .segmentPins(segmentPins),
		.keyData(keyData), .strapData(strapData), .alertSelected(alertSelected));
	lkpm_matrix_model far (.clock(clock), .cathodePins(cathodePins), .segmentPins(segmentPins),
		.strapLevel(strap), .keyPressed(keys), .segmentIn(segIn));
	task automatic chk(input bit ok, input string msg);
		compares++;
		if (!ok) begin
			$display("[ERR] %0t %s", $time, msg);
			err_count++;
		end
	endtask
	task automatic results();
		$display("Mismatches %0d of %0d checks", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// The note due this cycle is compared once the edge has landed.
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 1000) begin
			chk(1'b0, "timeout");
			results();
		end else begin
			#2;
			if (notes.size() > 0 && notes[0].due == cyc) begin
				m = notes.pop_front();
				chk(((cathodePins.out ^ m.cOutE) & m.cMask) === 8'h00 && (cathodePins.oe & m.cMask) === m.cMask, "cathode");
				chk(((segmentPins.out ^ m.sOutE) & m.sOutM) === 16'h0000, "segment level");
				chk(((segmentPins.oe ^ m.sOeE) & m.sMask) === 16'h0000, "segment drive");
				chk(((segmentPins.pd ^ m.sPdE) & m.sMask) === 16'h0000, "pull-down");
				if (m.kChk)
					chk(keyData === m.kExp, "key data");
				if (m.stChk)
					chk(strapData[2:0] === strap, "strap data");
			end
		end
	end
	// One cycle of stimulus; hold repeats the last values.
	task automatic step(input lkpm_phase_t ph, input bit hold);
		lkpm_note_t n;
		logic lv;
		@(posedge clock);
		#1;
		phase = ph;
		if (!hold) begin
			cs = 8'($random(seed));
			sd = 16'($random(seed));
			ss = 3'($random(seed));
			keys = 16'($random(seed));
		end
		lv = pol ? req : ~req;
		if (ph == LKPM_PH_DISPLAY)
			n = '{cyc + 1, ~cs, 8'hFF, {sel ? lv : sd[15], sd[14:0]}, 16'hFFFF, 16'hFFFF, 16'h0, 16'hFFFF, 16'h0, 0, 0};
		else if (ph == LKPM_PH_SCAN)
			n = '{cyc + 1, {4'h0, ss, 1'b1}, 8'h0F, {lv, 15'h0}, {sel, 15'h0}, {sel, 15'h0}, {~sel, 15'h7FFF},
				16'hFFFF, keys & 16'hFFF8 & {~sel, 15'h7FFF} & {16{|ss}}, hold, hold};
		else if (ph == LKPM_PH_POR)
			n = '{cyc + 1, 8'h01, 8'h01, 16'h0, 16'h0, 16'h0, 16'h0007, 16'h0007, 16'h0, 0, hold};
		else
			n = '{cyc + 1, 8'h00, 8'h00, {sel & lv, 15'h0}, 16'hFFFF, {sel, 15'h0007}, 16'h0, 16'hFFFF, 16'h0, 0, 0};
		notes.push_back(n);
	endtask
	// ==========================================================
	// Main sequence.
	initial begin
		{resetn, selWr, sel, pol, req, cs, sd, ss, keys} = '0;
		phase = LKPM_PH_IDLE;
		strap = 3'h5;
		repeat (6) @(posedge clock);
		#1;
		chk(cathodePins === {8'hFF, 8'h00} && segmentPins === '0 && alertSelected === 1'b0, "reset");
		resetn = 1'b1;
		step(LKPM_PH_POR, 0);
		step(LKPM_PH_POR, 1);
		for (int k = 0; k < 4; k++) begin
			@(posedge clock);
			#1;
			{selWr, sel, pol} = {1'b1, k == 1 || k == 2, k > 1};
			@(posedge clock);
			#1;
			selWr = 1'b0;
			@(posedge clock);
			#1;
			chk(alertSelected === sel, "select");
			for (int r = 0; r < 2; r++) begin
				req = r[0];
				repeat (3) @(posedge clock);
				repeat (4) begin
					step(LKPM_PH_DISPLAY, 0);
					step(LKPM_PH_SCAN, 0);
					step(LKPM_PH_SCAN, 1);
					step(LKPM_PH_IDLE, 0);
				end
			end
		end
		repeat (3) @(posedge clock);
		chk(notes.size() == 0, "notes never compared");
		results();
	end
endmodule
`default_nettype wire
